// ---- src/dac_reg_bank.sv ----
// Purpose: register bank of a voltage and current output converter on AHB-Lite
// Assumes: fault inputs are levels synchronous to hclk
// Notes: reads take one wait state, writes none
`timescale 1ns/1ns
module dac_reg_bank (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic clear_level_pin,
    input wire logic frame_crc_bad,
    input wire logic watchdog_timeout,
    input wire logic load_fault,
    input wire logic over_temp,
    input wire logic slew_busy,
    output logic irq,
    output dac_regs_pkg::word_t dac_code,
    output dac_regs_pkg::word_t zero_trim_value,
    output logic [2:0] range_sel,
    output logic [1:0] current_span_select,
    output logic both_outputs_enable,
    output logic sense_pulldown_enable,
    output logic voltage_output_en,
    output logic current_output_en,
    output logic slewing_active
);
    import dac_regs_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // bus slave
    bus_e bst_r, bst_nxt;
    logic [7:0] idx_r, idx_nxt;
    logic [31:0] hrdata_r, hrdata_nxt;
    logic take;
    logic wr;
    word_t wdata;
    word_t rd_word;
    assign take = hsel && hready && htrans[1];
    always_comb begin
        bst_nxt = bst_r;
        idx_nxt = idx_r;
        unique case (bst_r)
            B_RD1: begin
                bst_nxt = B_RD2;
            end
            B_IDLE, B_WR, B_RD2: begin
                bst_nxt = B_IDLE;
                if (take) begin
                    bst_nxt = hwrite ? B_WR : B_RD1;
                    idx_nxt = (haddr[31:10] == 22'h0) ? haddr[9:2] : IDX_NONE;
                end
            end
        endcase
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bst_r <= B_IDLE;
            idx_r <= IDX_NONE;
        end else begin
            bst_r <= bst_nxt;
            idx_r <= idx_nxt;
        end
    end
    assign wr = (bst_r == B_WR);
    assign wdata = hwdata[15:0];
    assign hreadyout = (bst_r != B_RD1);
    assign hresp = 1'b0;

    ////////////////////////////////////////////////////////////////////////
    // soft reset sequence
    logic [2:0] srst_cnt_r, srst_cnt_nxt;
    logic srst_act;
    logic srst_req;
    assign srst_act = (srst_cnt_r != 3'h0);
    assign srst_req = wr && (idx_r == IDX_RST) && wdata[RST_BIT] && !srst_act;
    always_comb begin
        srst_cnt_nxt = srst_cnt_r;
        if (srst_req) begin
            srst_cnt_nxt = SRST_CYCLES;
        end else if (srst_act) begin
            srst_cnt_nxt = srst_cnt_r - 3'h1;
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            srst_cnt_r <= 3'h0;
        end else begin
            srst_cnt_r <= srst_cnt_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // configuration registers
    word_t ctrl_r, ctrl_nxt;
    word_t cfg_r, cfg_nxt;
    word_t data_r, data_nxt;
    word_t zero_r, zero_nxt;
    logic wr_ok;
    assign wr_ok = wr && !srst_act;
    always_comb begin
        ctrl_nxt = ctrl_r;
        cfg_nxt = cfg_r;
        data_nxt = data_r;
        zero_nxt = zero_r;
        if (srst_act) begin
            ctrl_nxt = CTRL_RST;
            cfg_nxt = CFG_RST;
            data_nxt = DATA_RST;
            zero_nxt = ZERO_RST;
        end else if (wr_ok) begin
            unique case (idx_r)
                IDX_CTRL: begin
                    ctrl_nxt = wdata & CTRL_WMASK;
                    if (wdata[2:0] != ctrl_r[2:0]) begin
                        data_nxt = clear_code(wdata[2:0],
                            wdata[CTRL_CLR_BIT] | clear_level_pin);
                    end
                end
                IDX_CFG: begin
                    cfg_nxt = wdata & CFG_WMASK;
                end
                IDX_DATA: begin
                    data_nxt = wdata;
                end
                IDX_ZERO: begin
                    zero_nxt = wdata;
                end
                default: begin
                    ctrl_nxt = ctrl_r;
                end
            endcase
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_r <= CTRL_RST;
            cfg_r <= CFG_RST;
            data_r <= DATA_RST;
            zero_r <= ZERO_RST;
        end else begin
            ctrl_r <= ctrl_nxt;
            cfg_r <= cfg_nxt;
            data_r <= data_nxt;
            zero_r <= zero_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // output steering
    assign range_sel = ctrl_r[2:0];
    assign both_outputs_enable = cfg_r[CFG_DUAL_BIT];
    assign sense_pulldown_enable = cfg_r[CFG_PD_BIT];
    assign current_span_select = both_outputs_enable ?
        cfg_r[CFG_SPAN_LSB+1:CFG_SPAN_LSB] : ctrl_r[1:0];
    assign voltage_output_en = both_outputs_enable || !ctrl_r[2];
    assign current_output_en = both_outputs_enable || ctrl_r[2];
    assign dac_code = data_r;
    assign zero_trim_value = zero_r;

    ////////////////////////////////////////////////////////////////////////
    // monitoring and alarms
    logic [4:0] mon_cnt_r, mon_cnt_nxt;
    logic mon_tick;
    logic slew_r;
    logic [N_ALARM-1:0] cause_w;
    logic [N_ALARM-1:0] flag_w;
    assign mon_tick = (mon_cnt_r == 5'h0);
    always_comb begin
        mon_cnt_nxt = mon_tick ? MON_CYCLES - 5'h1 : mon_cnt_r - 5'h1;
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mon_cnt_r <= 5'h0;
            slew_r <= 1'b0;
        end else begin
            mon_cnt_r <= mon_cnt_nxt;
            slew_r <= slew_busy;
        end
    end
    assign slewing_active = slew_r;
    assign cause_w[AL_TEMP] = over_temp;
    assign cause_w[AL_LOAD] = load_fault;
    assign cause_w[AL_WDOG] = watchdog_timeout;
    assign cause_w[AL_CRC] = frame_crc_bad;
    for (genvar i = 0; i < N_ALARM; i++) begin : g_al
        alarm_if aif();
        assign aif.cause = cause_w[i];
        assign aif.tick = mon_tick;
        assign aif.srst = srst_act;
        assign flag_w[i] = aif.flag;
        alarm_latch u_al (
            .clk(hclk),
            .rst_n(hresetn),
            .al(aif)
        );
    end
    word_t status_w;
    assign status_w = {11'h000, flag_w[AL_CRC], flag_w[AL_WDOG],
        flag_w[AL_LOAD], slew_r, flag_w[AL_TEMP]};

    ////////////////////////////////////////////////////////////////////////
    // interrupt status and mask
    logic [N_ALARM-1:0] flag_d_r;
    logic [N_ALARM-1:0] ist_r, ist_nxt;
    logic [N_ALARM-1:0] imask_r, imask_nxt;
    logic [N_ALARM-1:0] rise_w;
    assign rise_w = flag_w & ~flag_d_r;
    always_comb begin
        ist_nxt = ist_r;
        imask_nxt = imask_r;
        if (srst_act) begin
            ist_nxt = '0;
            imask_nxt = '0;
        end else begin
            if (wr_ok && idx_r == IDX_IRQS) begin
                ist_nxt = ist_r & ~wdata[N_ALARM-1:0];
            end
            if (wr_ok && idx_r == IDX_IRQM) begin
                imask_nxt = wdata[N_ALARM-1:0];
            end
            ist_nxt = ist_nxt | rise_w;
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            flag_d_r <= '0;
            ist_r <= '0;
            imask_r <= '0;
        end else begin
            flag_d_r <= flag_w;
            ist_r <= ist_nxt;
            imask_r <= imask_nxt;
        end
    end
    assign irq = |(ist_r & imask_r);

    ////////////////////////////////////////////////////////////////////////
    // read data
    always_comb begin
        rd_word = 16'h0000;
        unique case (idx_r)
            IDX_CTRL: rd_word = ctrl_r;
            IDX_CFG: rd_word = cfg_r;
            IDX_DATA: rd_word = data_r;
            IDX_ZERO: rd_word = zero_r;
            IDX_STAT: rd_word = status_w;
            IDX_RST: rd_word = {15'h0000, srst_act};
            IDX_IRQS: rd_word = {12'h000, ist_r};
            IDX_IRQM: rd_word = {12'h000, imask_r};
            default: rd_word = 16'h0000;
        endcase
        hrdata_nxt = hrdata_r;
        if (bst_r == B_RD1) begin
            hrdata_nxt = {16'h0000, rd_word};
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_r <= 32'h0000_0000;
        end else begin
            hrdata_r <= hrdata_nxt;
        end
    end
    assign hrdata = hrdata_r;

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence s_srst_wr;
        wr && idx_r == IDX_RST && wdata[RST_BIT] && !srst_act;
    endsequence
    sequence s_defaults;
        ctrl_r == CTRL_RST && cfg_r == CFG_RST && data_r == DATA_RST
            && zero_r == ZERO_RST && ist_r == '0;
    endsequence
    sequence s_rng_wr;
        wr_ok && idx_r == IDX_CTRL && wdata[2:0] != ctrl_r[2:0];
    endsequence
    zero_write_a: assert property ((wr_ok && idx_r == IDX_ZERO)
        |=> zero_trim_value == $past(hwdata[15:0]))
        else $error("zero trim not stored");
    soft_reset_a: assert property (s_srst_wr |=> ##1 s_defaults)
        else $error("soft reset left a register set");
    reset_self_clear_a: assert property (s_srst_wr |=> srst_act[*4] ##1 !srst_act)
        else $error("reset bit did not clear itself");
    reset_high_bits_a: assert property ((wr && idx_r == IDX_RST && !wdata[RST_BIT]
        && !srst_act) |=> !srst_act)
        else $error("upper reset bits caused a reset");
    status_zero_a: assert property ((bst_r == B_RD2 && idx_r == IDX_STAT)
        |-> hrdata[31:5] == 27'h0)
        else $error("status upper bits not zero");
    status_now_a: assert property ((bst_r == B_RD1 && idx_r == IDX_STAT)
        |=> hreadyout && hrdata[4:0] == $past(status_w[4:0]))
        else $error("status read not current");
    slew_flag_a: assert property (slew_busy |=> slewing_active ##0 status_w[1])
        else $error("slewing bit not following slew");
    slew_fall_a: assert property (!slew_busy |=> !slewing_active ##0 !status_w[1])
        else $error("slewing bit stayed after slew");
    thermal_set_a: assert property ((over_temp && mon_tick && !srst_act)
        |=> status_w[0])
        else $error("thermal flag not set");
    range_clear_a: assert property (s_rng_wr |=> dac_code == clear_code(
        $past(hwdata[2:0]), $past(hwdata[CTRL_CLR_BIT]) | $past(clear_level_pin)))
        else $error("range change did not load clear code");
    span_keep_a: assert property ((wr_ok && idx_r == IDX_CFG) |=> $stable(dac_code))
        else $error("span change touched data");
    dual_span_a: assert property (both_outputs_enable |-> voltage_output_en
        && current_output_en && current_span_select == cfg_r[10:9])
        else $error("dual mode steering wrong");
    reset_read_a: assert property ((bst_r == B_RD1 && idx_r == IDX_RST)
        |=> hrdata[0] == $past(srst_act))
        else $error("reset bit read wrong");
endmodule

// ---- pkg/dac_regs_pkg.sv ----
// Purpose: shared constants and types of the output converter register bank
// Assumes: 32-bit AHB-Lite words, register index times four gives the byte address
// Notes: widths fixed, indices are word indices
package dac_regs_pkg;
    typedef logic [15:0] word_t;
    typedef enum logic [1:0] {
        B_IDLE = 2'b00,
        B_RD1 = 2'b01,
        B_RD2 = 2'b11,
        B_WR = 2'b10
    } bus_e;
    localparam logic [7:0] IDX_DATA = 8'h01;
    localparam logic [7:0] IDX_STAT = 8'h02;
    localparam logic [7:0] IDX_ZERO = 8'h09;
    localparam logic [7:0] IDX_CTRL = 8'h55;
    localparam logic [7:0] IDX_RST = 8'h56;
    localparam logic [7:0] IDX_CFG = 8'h57;
    localparam logic [7:0] IDX_IRQS = 8'h60;
    localparam logic [7:0] IDX_IRQM = 8'h61;
    localparam logic [7:0] IDX_NONE = 8'hFF;
    localparam word_t DATA_RST = 16'h0000;
    localparam word_t ZERO_RST = 16'h0000;
    localparam word_t CTRL_RST = 16'h0000;
    localparam word_t CFG_RST = 16'h0000;
    localparam word_t CTRL_WMASK = 16'h000F;
    localparam word_t CFG_WMASK = 16'h07FF;
    localparam word_t CODE_ZERO = 16'h0000;
    localparam word_t CODE_MID = 16'h8000;
    localparam int CTRL_CLR_BIT = 3;
    localparam int CFG_PD_BIT = 7;
    localparam int CFG_DUAL_BIT = 8;
    localparam int CFG_SPAN_LSB = 9;
    localparam int RST_BIT = 0;
    localparam int N_ALARM = 4;
    localparam int AL_TEMP = 0;
    localparam int AL_LOAD = 1;
    localparam int AL_WDOG = 2;
    localparam int AL_CRC = 3;
    localparam logic [2:0] SRST_CYCLES = 3'h4;
    localparam logic [4:0] MON_CYCLES = 5'h10;
    // clear code from range and clear level
    function automatic word_t clear_code(input logic [2:0] rng, input logic lvl);
        word_t c;
        c = CODE_ZERO;
        if (!rng[2] && (rng[1] ^ lvl)) begin
            c = CODE_MID;
        end
        return c;
    endfunction
endpackage

// ---- pkg/alarm_if.sv ----
// Purpose: carrier between the bank and one alarm latch
// Assumes: single clock domain
// Notes: tick marks a monitoring cycle
`timescale 1ns/1ns
interface alarm_if;
    logic cause;
    logic tick;
    logic srst;
    logic flag;
    modport latch (input cause, input tick, input srst, output flag);
    modport owner (output cause, output tick, output srst, input flag);
endinterface

// ---- src/alarm_latch.sv ----
// Purpose: one alarm flag updated once per monitoring cycle
// Assumes: cause is a level that stays high while the fault exists
// Notes: soft reset clears the flag, a lasting fault sets it again
`timescale 1ns/1ns
module alarm_latch (
    input wire logic clk,
    input wire logic rst_n,
    alarm_if.latch al
);
    logic flag_r, flag_nxt;
    always_comb begin
        flag_nxt = flag_r;
        if (al.srst) begin
            flag_nxt = 1'b0;
        end else if (al.tick) begin
            flag_nxt = al.cause;
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            flag_r <= 1'b0;
        end else begin
            flag_r <= flag_nxt;
        end
    end
    assign al.flag = flag_r;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    flag_set_a: assert property ((al.tick && al.cause && !al.srst) |=> al.flag)
        else $error("alarm not set on monitoring cycle");
    flag_hold_a: assert property ((al.flag && !al.tick && !al.srst) |=> al.flag)
        else $error("alarm dropped before cause resolved");
    flag_clr_a: assert property ((al.tick && !al.cause && !al.srst) |=> !al.flag)
        else $error("alarm kept after cause resolved");
endmodule

// ---- verification/fault_source.sv ----
// Purpose: far-side model that drives fault causes and the slew level
// Assumes: one clock, every cause is a level held while the fault lasts
// Notes: slow mode delays each change by four cycles instead of one
`timescale 1ns/1ns
module fault_source (
    input wire logic hclk,
    input wire logic [4:0] want,
    input wire logic slow,
    output logic [4:0] lvl
);
    logic [4:0] dly_r [4];
    ////////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge hclk) begin
        dly_r[0] <= want;
        for (int i = 1; i < 4; i++) begin
            dly_r[i] <= dly_r[i-1];
        end
    end
    // bits 3:0 alarm causes, bit 4 slew in progress
    assign lvl = slow ? dly_r[3] : dly_r[0];
endmodule

// ---- verification/dac_status_reset_output_cfg_test.sv ----
// Purpose: self-checking bench of the register bank over AHB-Lite
// Assumes: hready tied to hreadyout, one slave
// Notes: expected values come from the register and alarm behaviour
`timescale 1ns/1ns
module dac_status_reset_output_cfg_test;
    import dac_regs_pkg::*;
    logic hclk, hresetn, hsel, hwrite, clear_level_pin, slow;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans, current_span_select;
    logic [2:0] hsize, range_sel, r;
    logic [4:0] want, lvl;
    logic hreadyout, hresp, irq, both_outputs_enable, sense_pulldown_enable;
    logic voltage_output_en, current_output_en, slewing_active;
    word_t dac_code, zero_trim_value;
    int error_cnt = 0;
    int n_compared = 0;
    int cyc = 0;
    int sb [4] = '{0, 2, 3, 4};
    ////////////////////////////////////////////////////////////////////////////////
    dac_reg_bank dut_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(hreadyout), .hreadyout, .hresp, .hrdata, .clear_level_pin,
        .frame_crc_bad(lvl[AL_CRC]), .watchdog_timeout(lvl[AL_WDOG]),
        .load_fault(lvl[AL_LOAD]), .over_temp(lvl[AL_TEMP]), .slew_busy(lvl[4]), .irq,
        .dac_code, .zero_trim_value, .range_sel, .current_span_select, .both_outputs_enable,
        .sense_pulldown_enable, .voltage_output_en, .current_output_en, .slewing_active);
    fault_source far_u (.hclk, .want, .slow, .lvl);
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        hclk = 1'b0;
        forever #10 hclk = ~hclk;
    end
    always @(posedge hclk) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            end_of_test();
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic end_of_test();
        if (error_cnt == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    // address phase held until hready, then data phase held until hready
    task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= a;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic wr(input logic [7:0] i, input logic [31:0] d);
        xfer(1'b1, {22'h0, i, 2'h0}, d);
    endtask
    task automatic rc(input string n, input logic [7:0] i, input logic [31:0] e);
        xfer(1'b0, {22'h0, i, 2'h0}, 32'h0);
        chk(n, e, rd);
    endtask
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge hclk);
    endtask
    function automatic logic [31:0] clr_exp(input logic [2:0] rg, input logic l);
        if (rg[2]) begin
            return 32'h0;
        end
        return (rg[1] ^ l) ? 32'h8000 : 32'h0;
    endfunction
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        hsel = 1'b0;
        htrans = 2'h0;
        hwrite = 1'b0;
        haddr = 32'h0;
        hwdata = 32'h0;
        hsize = 3'h2;
        clear_level_pin = 1'b0;
        want = 5'h00;
        slow = 1'b0;
        hresetn = 1'b0;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rc("zero_rst", IDX_ZERO, 32'h0);
        rc("stat_rst", IDX_STAT, 32'h0);
        chk("hresp", 32'h0, {31'h0, hresp});
        wr(IDX_ZERO, 32'hFFFF_8001);
        rc("zero", IDX_ZERO, 32'h0000_8001);
        chk("zero_port", 32'h8001, {16'h0, zero_trim_value});
        wr(IDX_STAT, 32'h0000_FFFF);
        rc("stat_ro", IDX_STAT, 32'h0);
        xfer(1'b1, 32'h0000_0424, 32'h1111);
        rc("zero_keep", IDX_ZERO, 32'h0000_8001);
        xfer(1'b0, 32'h0000_0424, 32'h0);
        chk("unmapped", 32'h0, rd);
        rc("none", IDX_NONE, 32'h0);
        // each range change reloads the data word, level from pin or ctrl bit
        for (int i = 1; i <= 16; i++) begin
            r = i[2:0];
            wr(IDX_DATA, 32'h1234);
            clear_level_pin <= i[3] & i[0];
            wr(IDX_CTRL, {28'h0, i[3] & ~i[0], r});
            rc("clr_code", IDX_DATA, clr_exp(r, i[3]));
            chk("out_en", {30'h0, ~r[2], r[2]}, {30'h0, voltage_output_en, current_output_en});
            chk("range", {29'h0, r}, {29'h0, range_sel});
            chk("code_port", clr_exp(r, i[3]), {16'h0, dac_code});
        end
        wr(IDX_DATA, 32'h5555);
        wr(IDX_CTRL, 32'h0);
        rc("same_rng", IDX_DATA, 32'h5555);
        wr(IDX_CTRL, 32'h1);
        wr(IDX_DATA, 32'hABCD);
        wr(IDX_CFG, 32'h0500);
        rc("dual_data", IDX_DATA, 32'hABCD);
        chk("dual_span", 32'h2, {30'h0, current_span_select});
        chk("dual_en", 32'h3, {30'h0, voltage_output_en, current_output_en});
        wr(IDX_CFG, 32'h0300);
        rc("span_data", IDX_DATA, 32'hABCD);
        chk("span2", 32'h1, {30'h0, current_span_select});
        wr(IDX_CFG, 32'h0);
        wr(IDX_CTRL, 32'h5);
        wait_cyc(1);
        chk("single_span", 32'h1, {30'h0, current_span_select});
        chk("single_en", 32'h1, {30'h0, voltage_output_en, current_output_en});
        // each alarm: set, irq raised and masked, resolved, cleared by one
        for (int a = 0; a < 4; a++) begin
            wr(IDX_IRQM, 32'hF);
            want <= 5'(1 << a);
            slow <= a[0];
            wait_cyc(40);
            rc("flag", IDX_STAT, 32'(1 << sb[a]));
            rc("irq_stat", IDX_IRQS, 32'(1 << a));
            chk("irq_on", 32'h1, {31'h0, irq});
            wr(IDX_IRQM, 32'h0);
            wait_cyc(1);
            chk("irq_mask", 32'h0, {31'h0, irq});
            want <= 5'h00;
            wait_cyc(40);
            rc("flag_clr", IDX_STAT, 32'h0);
            rc("irq_sticky", IDX_IRQS, 32'(1 << a));
            wr(IDX_IRQS, 32'(1 << a));
            rc("irq_w1c", IDX_IRQS, 32'h0);
        end
        slow <= 1'b0;
        want <= 5'h10;
        wait_cyc(3);
        rc("slewing", IDX_STAT, 32'h2);
        chk("slew_port", 32'h1, {31'h0, slewing_active});
        want <= 5'h00;
        wait_cyc(6);
        rc("slew_end", IDX_STAT, 32'h0);
        // soft reset: upper bits do nothing, bit 0 restores defaults
        want <= 5'h01;
        wait_cyc(40);
        wr(IDX_ZERO, 32'h7FFF);
        wr(IDX_CFG, 32'h0180);
        wr(IDX_IRQM, 32'hF);
        wr(IDX_RST, 32'hFFFE);
        rc("rst_upper", IDX_ZERO, 32'h7FFF);
        rc("rst_upper_cfg", IDX_CFG, 32'h0180);
        chk("pd_keep", 32'h1, {31'h0, sense_pulldown_enable});
        wr(IDX_RST, 32'h1);
        rc("rst_busy", IDX_RST, 32'h1);
        wait_cyc(8);
        rc("rst_self", IDX_RST, 32'h0);
        rc("rst_zero", IDX_ZERO, 32'h0);
        rc("rst_cfg", IDX_CFG, 32'h0);
        chk("pd_rst", 32'h0, {31'h0, sense_pulldown_enable});
        rc("rst_mask", IDX_IRQM, 32'h0);
        chk("rst_irq", 32'h0, {31'h0, irq});
        wait_cyc(40);
        rc("reassert", IDX_STAT, 32'h1);
        // power-on reset in mid-run: trim back to zero, lasting fault flagged again
        wr(IDX_ZERO, 32'h1234);
        hresetn <= 1'b0;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rc("por_zero", IDX_ZERO, 32'h0);
        rc("por_flag", IDX_STAT, 32'h1);
        want <= 5'h00;
        wait_cyc(2);
        end_of_test();
    end
endmodule
